// File: bfifo_pkg.sv
package bfifo_pkg;

    // queue geometry
    localparam int          DATA_W  = 36;
    localparam int          ADDR_W  = 8;
    localparam int          PTR_W   = 9;
    localparam int          OFFS_W  = 9;
    localparam logic [8:0]  DEPTH   = 9'h100;

    // register map (byte addresses)
    localparam logic [3:0]  CTRL_ADDR      = 4'h0;
    localparam logic [3:0]  Q1_OFFS_ADDR   = 4'h4;
    localparam logic [3:0]  Q2_OFFS_ADDR   = 4'h8;
    localparam logic [3:0]  STATUS_ADDR    = 4'hc;

    // field positions
    localparam int          CTRL_MODE_BIT  = 0;
    localparam int          OFFS_EMPTY_LSB = 0;
    localparam int          OFFS_FULL_LSB  = 16;

    // reset values
    localparam logic        MODE_RST       = 1'b0;
    localparam logic [8:0]  OFFS_RST       = 9'h008;

    // answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic {
        STANDARD_TIMING_MODE        = 1'b0,
        FIRST_WORD_FALL_THROUGH_MODE = 1'b1
    } bfifo_mode_t;

    typedef struct packed {
        logic select_n;
        logic direction;
        logic enable;
        logic mailbox_select;
    } bfifo_port_ctrl_t;

    typedef struct packed {
        logic empty_or_ready;
        logic almost_empty;
        logic almost_full;
        logic full_or_input_ready;
    } bfifo_port_flags_t;

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        return b;
    endfunction

endpackage

// File: bfifo_top.sv
// Overview of operation
// - every queue flag passes two flops stepped by its owning port clock.
// - port A flags follow port A clock, port B flags port B clock.
// - port A decode: select, direction, enable, mailbox select pick queue or mailbox.
// - port B decode mirrors port A with inverted direction sense.
// - port A mailbox read sets the mailbox-two flag high.
// - port B mailbox read sets the mailbox-one flag high.
// - fall-through mode: ready high means fresh output; low ignores reads.
// - standard mode: empty flag high means words wait; low ignores reads.
// - empty/ready flag is synchronized to the reading port clock.
// - read pointer advances whenever a word loads the output register.
// - empty side compares pointers: empty, empty plus one, empty plus two.
// - fall-through: word and ready flag reach output on third read edge.
// - standard: empty flag rises on second read edge after write.
// - an edge too close after a write counts from the next edge.
// - queue one flags follow memory word count with offsets X1 and Y1.
// - queue two uses X2 and Y2, flags split across the ports.
// - output register word not counted; fall-through first word loads unasked.
// - a word moved to the output register frees its memory slot.
// - mode setting picks ready/input-ready or empty/full meaning.
// - queue one offsets drive B almost-empty and A almost-full, queue two reverse.
// - writes are ignored while full/input-ready is low.
// - mailbox write drives its flag low; further writes ignored meanwhile.
// - driven data comes from queue output or mailbox per mailbox select.
// - full/input-ready rises on second writing clock edge after a read.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module bfifo_queue (
    // system
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // configuration
    input  wire logic                          mode_first_word_fall_through_mode,
    input  wire logic [bfifo_pkg::OFFS_W-1:0]  empty_offset,
    input  wire logic [bfifo_pkg::OFFS_W-1:0]  full_offset,
    // writing port
    input  wire logic                          wr_edge,
    input  wire logic                          wr_req,
    input  wire logic [bfifo_pkg::DATA_W-1:0]  wr_data,
    output logic                               almost_full,
    output logic                               full_or_input_ready,
    // reading port
    input  wire logic                          rd_edge,
    input  wire logic                          rd_req,
    output logic [bfifo_pkg::DATA_W-1:0]       out_data,
    output logic                               empty_or_ready,
    output logic                               almost_empty
);
    logic [bfifo_pkg::DATA_W-1:0] mem_reg [2**bfifo_pkg::ADDR_W];
    logic [bfifo_pkg::PTR_W-1:0]  wptr_reg;
    logic [bfifo_pkg::PTR_W-1:0]  wgray_reg;
    logic [bfifo_pkg::PTR_W-1:0]  rptr_reg;
    logic [bfifo_pkg::PTR_W-1:0]  rgray_reg;
    logic [bfifo_pkg::PTR_W-1:0]  wgray_s1_reg;
    logic [bfifo_pkg::PTR_W-1:0]  wgray_s2_reg;
    logic [bfifo_pkg::PTR_W-1:0]  rgray_s1_reg;
    logic [bfifo_pkg::PTR_W-1:0]  rgray_s2_reg;
    logic [bfifo_pkg::DATA_W-1:0] out_reg;
    logic                         ready_reg;
    logic [bfifo_pkg::PTR_W-1:0]  rd_count;
    logic [bfifo_pkg::PTR_W-1:0]  wr_count;
    logic                         mem_ne;
    logic                         do_write;
    logic                         do_load;
    logic [bfifo_pkg::PTR_W-1:0]  wptr_next;
    logic [bfifo_pkg::PTR_W-1:0]  rptr_next;

    // word counts exclude the output register
    assign rd_count  = bfifo_pkg::gray2bin(wgray_s2_reg) - rptr_reg;
    assign wr_count  = wptr_reg - bfifo_pkg::gray2bin(rgray_s2_reg);
    assign mem_ne    = (rd_count != '0);
    assign wptr_next = wptr_reg + 9'h001;
    assign rptr_next = rptr_reg + 9'h001;

    assign full_or_input_ready = (wr_count != bfifo_pkg::DEPTH);
    assign almost_full  = (wr_count < (bfifo_pkg::DEPTH - full_offset));
    assign almost_empty = (rd_count > empty_offset);
    assign empty_or_ready = mode_first_word_fall_through_mode ? ready_reg : mem_ne;
    assign out_data = out_reg;

    assign do_write = wr_edge & wr_req & full_or_input_ready;
    // fall-through loads unasked while ready is low, else on a granted read
    assign do_load = rd_edge & mem_ne &
                     (mode_first_word_fall_through_mode ? (~ready_reg | rd_req) : rd_req);

    always_ff @(posedge aclk) begin
        if (do_write) begin
            mem_reg[wptr_reg[bfifo_pkg::ADDR_W-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_reg  <= '0;
            wgray_reg <= '0;
        end else if (do_write) begin
            wptr_reg  <= wptr_next;
            wgray_reg <= bfifo_pkg::bin2gray(wptr_next);
        end
    end

    // read pointer moves on each output load, freeing its slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rptr_reg  <= '0;
            rgray_reg <= '0;
            out_reg   <= '0;
        end else if (do_load) begin
            rptr_reg  <= rptr_next;
            rgray_reg <= bfifo_pkg::bin2gray(rptr_next);
            out_reg   <= mem_reg[rptr_reg[bfifo_pkg::ADDR_W-1:0]];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_reg <= 1'b0;
        end else if (rd_edge) begin
            if (do_load) begin
                ready_reg <= 1'b1;
            end else if (rd_req) begin
                ready_reg <= 1'b0;
            end
        end
    end

    // write pointer into the reading port: two stages on its edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wgray_s1_reg <= '0;
            wgray_s2_reg <= '0;
        end else if (rd_edge) begin
            wgray_s1_reg <= wgray_reg;
            wgray_s2_reg <= wgray_s1_reg;
        end
    end

    // read pointer into the writing port: two stages on its edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rgray_s1_reg <= '0;
            rgray_s2_reg <= '0;
        end else if (wr_edge) begin
            rgray_s1_reg <= rgray_reg;
            rgray_s2_reg <= rgray_s1_reg;
        end
    end

endmodule // bfifo_queue

module bfifo_top (
    // system
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic [31:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // port a pins
    input  wire logic                          port_a_clock,
    input  wire bfifo_pkg::bfifo_port_ctrl_t   port_a_ctrl,
    input  wire logic [bfifo_pkg::DATA_W-1:0]  port_a_data_in,
    output logic [bfifo_pkg::DATA_W-1:0]       port_a_data_out,
    output logic                               port_a_data_oe,
    output bfifo_pkg::bfifo_port_flags_t       port_a_flags,
    // port b pins
    input  wire logic                          port_b_clock,
    input  wire bfifo_pkg::bfifo_port_ctrl_t   port_b_ctrl,
    input  wire logic [bfifo_pkg::DATA_W-1:0]  port_b_data_in,
    output logic [bfifo_pkg::DATA_W-1:0]       port_b_data_out,
    output logic                               port_b_data_oe,
    output bfifo_pkg::bfifo_port_flags_t       port_b_flags,
    // mailbox flags
    output logic                               mailbox_one_flag,
    output logic                               mailbox_two_flag
);
    // pin synchronisers: {clock, ctrl, data}
    localparam int SYNC_W = 1 + 4 + bfifo_pkg::DATA_W;
    logic [SYNC_W-1:0]              a_s1_reg;
    logic [SYNC_W-1:0]              a_s2_reg;
    logic [SYNC_W-1:0]              b_s1_reg;
    logic [SYNC_W-1:0]              b_s2_reg;
    logic                           a_clk_s3_reg;
    logic                           b_clk_s3_reg;
    logic                           a_rise;
    logic                           b_rise;
    bfifo_pkg::bfifo_port_ctrl_t    a_ctrl;
    bfifo_pkg::bfifo_port_ctrl_t    b_ctrl;
    logic [bfifo_pkg::DATA_W-1:0]   a_data;
    logic [bfifo_pkg::DATA_W-1:0]   b_data;
    logic                           a_act;
    logic                           b_act;
    logic                           q1_wr;
    logic                           q1_rd;
    logic                           q2_wr;
    logic                           q2_rd;
    logic                           mb1_wr;
    logic                           mb1_rd;
    logic                           mb2_wr;
    logic                           mb2_rd;
    logic [bfifo_pkg::DATA_W-1:0]   mbox1_reg;
    logic [bfifo_pkg::DATA_W-1:0]   mbox2_reg;
    logic                           mailbox_one_flag_reg;
    logic                           mailbox_two_flag_reg;
    logic [bfifo_pkg::DATA_W-1:0]   q1_out;
    logic [bfifo_pkg::DATA_W-1:0]   q2_out;
    logic                           mode_reg;
    logic [bfifo_pkg::OFFS_W-1:0]   x1_reg;
    logic [bfifo_pkg::OFFS_W-1:0]   y1_reg;
    logic [bfifo_pkg::OFFS_W-1:0]   x2_reg;
    logic [bfifo_pkg::OFFS_W-1:0]   y2_reg;
    logic                           bvalid_reg;
    logic [1:0]                     bresp_reg;
    logic                           rvalid_reg;
    logic [31:0]                    rdata_reg;
    logic [1:0]                     rresp_reg;
    logic                           wr_fire;
    logic [3:0]                     waddr;
    logic [3:0]                     raddr;
    logic [31:0]                    q1_offs_word;
    logic [31:0]                    q2_offs_word;
    logic [31:0]                    status_word;
    logic [31:0]                    q1_merged;
    logic [31:0]                    q2_merged;

    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_s1_reg     <= '0;
            a_s2_reg     <= '0;
            a_clk_s3_reg <= 1'b0;
            b_s1_reg     <= '0;
            b_s2_reg     <= '0;
            b_clk_s3_reg <= 1'b0;
        end else begin
            a_s1_reg     <= {port_a_clock, port_a_ctrl, port_a_data_in};
            a_s2_reg     <= a_s1_reg;
            a_clk_s3_reg <= a_s2_reg[SYNC_W-1];
            b_s1_reg     <= {port_b_clock, port_b_ctrl, port_b_data_in};
            b_s2_reg     <= b_s1_reg;
            b_clk_s3_reg <= b_s2_reg[SYNC_W-1];
        end
    end

    assign a_rise = a_s2_reg[SYNC_W-1] & ~a_clk_s3_reg;
    assign b_rise = b_s2_reg[SYNC_W-1] & ~b_clk_s3_reg;
    assign a_ctrl = a_s2_reg[SYNC_W-2 -: 4];
    assign b_ctrl = b_s2_reg[SYNC_W-2 -: 4];
    assign a_data = a_s2_reg[bfifo_pkg::DATA_W-1:0];
    assign b_data = b_s2_reg[bfifo_pkg::DATA_W-1:0];

    // port decode
    assign a_act  = a_rise & ~a_ctrl.select_n & a_ctrl.enable;
    assign q1_wr  = a_act & a_ctrl.direction & ~a_ctrl.mailbox_select;
    assign mb1_wr = a_act & a_ctrl.direction & a_ctrl.mailbox_select & mailbox_one_flag_reg;
    assign q2_rd  = a_act & ~a_ctrl.direction & ~a_ctrl.mailbox_select;
    assign mb2_rd = a_act & ~a_ctrl.direction & a_ctrl.mailbox_select;
    assign b_act  = b_rise & ~b_ctrl.select_n & b_ctrl.enable;
    assign q2_wr  = b_act & ~b_ctrl.direction & ~b_ctrl.mailbox_select;
    assign mb2_wr = b_act & ~b_ctrl.direction & b_ctrl.mailbox_select & mailbox_two_flag_reg;
    assign q1_rd  = b_act & b_ctrl.direction & ~b_ctrl.mailbox_select;
    assign mb1_rd = b_act & b_ctrl.direction & b_ctrl.mailbox_select;

    bfifo_queue u_a_to_b_queue (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .mode_first_word_fall_through_mode           (mode_reg),
        .empty_offset        (x1_reg),
        .full_offset         (y1_reg),
        .wr_edge             (a_rise),
        .wr_req              (q1_wr),
        .wr_data             (a_data),
        .almost_full         (port_a_flags.almost_full),
        .full_or_input_ready (port_a_flags.full_or_input_ready),
        .rd_edge             (b_rise),
        .rd_req              (q1_rd),
        .out_data            (q1_out),
        .empty_or_ready      (port_b_flags.empty_or_ready),
        .almost_empty        (port_b_flags.almost_empty)
    );

    bfifo_queue u_b_to_a_queue (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .mode_first_word_fall_through_mode           (mode_reg),
        .empty_offset        (x2_reg),
        .full_offset         (y2_reg),
        .wr_edge             (b_rise),
        .wr_req              (q2_wr),
        .wr_data             (b_data),
        .almost_full         (port_b_flags.almost_full),
        .full_or_input_ready (port_b_flags.full_or_input_ready),
        .rd_edge             (a_rise),
        .rd_req              (q2_rd),
        .out_data            (q2_out),
        .empty_or_ready      (port_a_flags.empty_or_ready),
        .almost_empty        (port_a_flags.almost_empty)
    );

    // mailboxes; a read setting the flag wins over a same-cycle write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mbox1_reg <= '0;
            mailbox_one_flag_reg  <= 1'b1;
        end else begin
            if (mb1_wr) begin
                mbox1_reg <= a_data;
            end
            if (mb1_rd) begin
                mailbox_one_flag_reg <= 1'b1;
            end else if (mb1_wr) begin
                mailbox_one_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mbox2_reg <= '0;
            mailbox_two_flag_reg  <= 1'b1;
        end else begin
            if (mb2_wr) begin
                mbox2_reg <= b_data;
            end
            if (mb2_rd) begin
                mailbox_two_flag_reg <= 1'b1;
            end else if (mb2_wr) begin
                mailbox_two_flag_reg <= 1'b0;
            end
        end
    end

    assign mailbox_one_flag = mailbox_one_flag_reg;
    assign mailbox_two_flag = mailbox_two_flag_reg;

    // data drive
    assign port_a_data_oe  = ~a_ctrl.select_n & ~a_ctrl.direction;
    assign port_b_data_oe  = ~b_ctrl.select_n & b_ctrl.direction;
    assign port_a_data_out = a_ctrl.mailbox_select ? mbox2_reg : q2_out;
    assign port_b_data_out = b_ctrl.mailbox_select ? mbox1_reg : q1_out;

    // axi4-lite slave: address and data taken together
    assign waddr         = s_axi_awaddr[3:0];
    assign raddr         = s_axi_araddr[3:0];
    assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    assign q1_offs_word = {7'h00, y1_reg, 7'h00, x1_reg};
    assign q2_offs_word = {7'h00, y2_reg, 7'h00, x2_reg};
    assign status_word  = {22'h0, mailbox_two_flag_reg, mailbox_one_flag_reg, port_b_flags, port_a_flags};
    assign q1_merged    = merge_strb(q1_offs_word, s_axi_wdata, s_axi_wstrb);
    assign q2_merged    = merge_strb(q2_offs_word, s_axi_wdata, s_axi_wstrb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg   <= bfifo_pkg::MODE_RST;
            x1_reg     <= bfifo_pkg::OFFS_RST;
            y1_reg     <= bfifo_pkg::OFFS_RST;
            x2_reg     <= bfifo_pkg::OFFS_RST;
            y2_reg     <= bfifo_pkg::OFFS_RST;
            bvalid_reg <= 1'b0;
            bresp_reg  <= bfifo_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= bfifo_pkg::RESP_OKAY;
            if (s_axi_awaddr[31:4] != '0) begin
                bresp_reg <= bfifo_pkg::RESP_SLVERR;
            end else begin
                case (waddr)
                    bfifo_pkg::CTRL_ADDR: begin
                        if (s_axi_wstrb[0]) begin
                            mode_reg <= s_axi_wdata[bfifo_pkg::CTRL_MODE_BIT];
                        end
                    end
                    bfifo_pkg::Q1_OFFS_ADDR: begin
                        y1_reg <= q1_merged[bfifo_pkg::OFFS_FULL_LSB +: bfifo_pkg::OFFS_W];
                        x1_reg <= q1_merged[bfifo_pkg::OFFS_EMPTY_LSB +: bfifo_pkg::OFFS_W];
                    end
                    bfifo_pkg::Q2_OFFS_ADDR: begin
                        y2_reg <= q2_merged[bfifo_pkg::OFFS_FULL_LSB +: bfifo_pkg::OFFS_W];
                        x2_reg <= q2_merged[bfifo_pkg::OFFS_EMPTY_LSB +: bfifo_pkg::OFFS_W];
                    end
                    bfifo_pkg::STATUS_ADDR: begin
                        bresp_reg <= bfifo_pkg::RESP_OKAY;
                    end
                    default: begin
                        bresp_reg <= bfifo_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= bfifo_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= bfifo_pkg::RESP_OKAY;
            rdata_reg  <= '0;
            if (s_axi_araddr[31:4] != '0) begin
                rresp_reg <= bfifo_pkg::RESP_SLVERR;
            end else begin
                case (raddr)
                    bfifo_pkg::CTRL_ADDR:    rdata_reg <= {31'h00000000, mode_reg};
                    bfifo_pkg::Q1_OFFS_ADDR: rdata_reg <= q1_offs_word;
                    bfifo_pkg::Q2_OFFS_ADDR: rdata_reg <= q2_offs_word;
                    bfifo_pkg::STATUS_ADDR:  rdata_reg <= status_word;
                    default:                 rresp_reg <= bfifo_pkg::RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule // bfifo_top

`default_nettype wire

// File: bfifo_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bfifo_sva (
    // bus
    input wire logic                         aclk,
    input wire logic                         aresetn,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    input wire logic [31:0]                  s_axi_rdata,
    input wire logic [1:0]                   s_axi_rresp,
    // flags
    input wire bfifo_pkg::bfifo_port_flags_t port_a_flags,
    input wire bfifo_pkg::bfifo_port_flags_t port_b_flags,
    input wire logic                         mailbox_one_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_b_after: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_r_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    chk_a_empty_order: assert property (port_a_flags.almost_empty |-> port_a_flags.empty_or_ready)
        else $error("port a almost empty without data");
    chk_b_empty_order: assert property (port_b_flags.almost_empty |-> port_b_flags.empty_or_ready)
        else $error("port b almost empty without data");
    chk_a_full_order: assert property (!port_a_flags.full_or_input_ready |-> !port_a_flags.almost_full)
        else $error("port a full but not almost full");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($fell(mailbox_one_flag));
    cover property ($rose(port_b_flags.empty_or_ready));
endmodule // bfifo_sva
bind bfifo_top bfifo_sva bfifo_sva_inst (.*);
`default_nettype wire

// File: bfifo_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfifo_port_model (
    // pins toward the device
    output logic                          clk,
    output bfifo_pkg::bfifo_port_ctrl_t   ctrl,
    output logic [bfifo_pkg::DATA_W-1:0]  data,
    input wire logic                      oe
);
    initial begin
        clk = 1'b0;
        ctrl = 4'h8;
        data = '0;
    end
    // free-running, eight system periods
    always #200 clk = ~clk;
    // released lines show the inverse of the last value
    always @(posedge oe) data = ~data;
    task automatic op(input logic [3:0] c, input logic [35:0] d);
        @(negedge clk);
        ctrl = c;
        data = d;
        @(negedge clk);
        ctrl.enable = 1'b0;
    endtask
endmodule // bfifo_port_model
`default_nettype wire

// File: bfifo_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t %h %h", $time, a, e); end end
module bfifo_top_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, port_a_clock, port_b_clock, port_a_data_oe, port_b_data_oe;
    logic mailbox_one_flag, mailbox_two_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    bfifo_pkg::bfifo_port_ctrl_t port_a_ctrl, port_b_ctrl;
    bfifo_pkg::bfifo_port_flags_t port_a_flags, port_b_flags;
    logic [35:0] port_a_data_in, port_b_data_in, port_a_data_out, port_b_data_out;
    logic [65:0] rows [5] = '{{32'h0, 32'h0, 2'h0}, {32'h4, 32'h80008, 2'h0},
        {32'h8, 32'h80008, 2'h0}, {32'hc, 32'h333, 2'h0}, {32'h10, 32'h0, 2'h2}};
    int err_count = 0, n_tests = 0, cyc = 0;
    bfifo_top bfifo_top_inst (.*);
    bfifo_port_model model_a (.clk(port_a_clock), .ctrl(port_a_ctrl),
        .data(port_a_data_in), .oe(port_a_data_oe));
    bfifo_port_model model_b (.clk(port_b_clock), .ctrl(port_b_ctrl),
        .data(port_b_data_in), .oe(port_b_data_oe));
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (++cyc > 20000) begin
        err_count++;
        test_done();
    end
    task automatic test_done();
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awvalid && s_axi_awready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask
    task automatic axr(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    initial begin
        logic [31:0] a, e;
        logic [1:0] r;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        foreach (rows[i]) begin
            {a, e, r} = rows[i];
            axr(a);
            `CHK(rd, e)
            `CHK(rs, r)
        end
        `CHK(port_a_flags, 4'h3)
        axw(32'h10, 32'h1);
        `CHK(rs, bfifo_pkg::RESP_SLVERR)
        axw(32'h4, 32'h80001);
        model_a.op(4'h6, 36'h123456789);
        model_a.op(4'h6, 36'h0abcdef01);
        repeat (3) @(negedge port_b_clock);
        `CHK(port_b_flags[3:2], 2'h3)
        model_b.op(4'h6, 36'h0);
        `CHK(port_b_data_out, 36'h123456789)
        repeat (3) @(negedge port_b_clock);
        `CHK(port_b_flags.almost_empty, 1'b0)
        model_a.op(4'h2, 36'h0);
        `CHK(port_a_data_out, 36'h0)
        model_a.op(4'h7, 36'h5);
        model_a.op(4'h7, 36'h6);
        `CHK(mailbox_one_flag, 1'b0)
        model_b.op(4'h7, 36'h0);
        `CHK(port_b_data_out, 36'h5)
        `CHK(mailbox_one_flag, 1'b1)
        model_b.op(4'h3, 36'h9);
        `CHK(mailbox_two_flag, 1'b0)
        model_a.op(4'h3, 36'h0);
        `CHK(port_a_data_out, 36'h9)
        `CHK(mailbox_two_flag, 1'b1)
        model_b.op(4'h6, 36'h0);
        `CHK(port_b_data_out, 36'h0abcdef01)
        @(posedge aclk);
        axw(32'h0, 32'h1);
        model_b.op(4'h2, 36'h77);
        `CHK(port_a_flags.empty_or_ready, 1'b0)
        repeat (30) @(negedge aclk);
        `CHK(port_a_flags.empty_or_ready, 1'b1)
        model_a.op(4'h2, 36'h0);
        `CHK(port_a_data_out, 36'h77)
        `CHK(port_a_flags.empty_or_ready, 1'b0)
        test_done();
    end
endmodule // bfifo_top_test
`default_nettype wire
